// [bench/tmrcm_monitor.sv]
// Purpose: Port-level assertions for the timer 2 control block.
// Assumes: One clock; outputs stay quiet while reset is low.
// Notes:   Bound to tmrcm_top after the module.
`timescale 1ns/100ps
`include "tmrcm_defs.svh"
module tmrcm_monitor
  import tmrcm_pkg::*;
(
  input wire logic CLK, // Clock.
  input wire logic ARST_N, // Reset, active low.
  input wire logic PSEL, // APB select.
  input wire logic PENABLE, // APB access.
  input wire logic PWRITE, // APB direction.
  input wire logic [11:0] PADDR, // APB address.
  input wire logic [31:0] PRDATA, // APB read data.
  input wire logic PREADY, // APB ready.
  input wire logic PSLVERR, // APB error.
  input wire logic MC_TICK, // Machine cycle tick.
  input wire logic IRQ // Interrupt.
);
  // ====================
  // Decode
  wire acc = PSEL && PENABLE;
  wire [9:0] idx = PADDR[11:2];
  wire mapped = idx >= `TMRCM_IDX_CTRL && idx <= `TMRCM_IDX_CTRL_CLR;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ====================
  // Checks
  ready_late_a: assert property ($rose(acc) |-> !PREADY ##1 PREADY)
    else $error("ready not one cycle into access");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside ready");
  slverr_ready_a: assert property (PSLVERR |-> PREADY && !mapped)
    else $error("stray error response");
  unmapped_err_a: assert property (PREADY && !mapped |-> PSLVERR)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (PREADY && mapped |-> !PSLVERR)
    else $error("mapped access refused");
  ckmode_read_a: assert property (
    PREADY && !PWRITE && idx == `TMRCM_IDX_CKMODE |-> PRDATA[31:1] == 31'h0)
    else $error("reserved clock-mode bits not zero");
  mc_gap_a: assert property (MC_TICK |=> !MC_TICK [*5])
    else $error("machine cycle shorter than six clocks");
  cover property (PSLVERR);
  cover property (MC_TICK ##6 MC_TICK);
  cover property (IRQ);
endmodule

bind tmrcm_top tmrcm_monitor i_tmrcm_monitor (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .MC_TICK(MC_TICK), .IRQ(IRQ));

// [bench/tmrcm_partner.sv]
// Purpose: Far-side model of the trigger, count and timer 1 lines.
// Assumes: Both pins have pull-ups and idle high.
// Notes:   Counts serial ticks so the bench sees the baud source.
`timescale 1ns/100ps
module tmrcm_partner (
  input wire logic clk, // Clock.
  input wire logic [1:0] cmd, // 1 trigger, 2 count pin, 3 timer 1.
  input wire logic rx_tick, // Receive tick.
  input wire logic tx_tick, // Transmit tick.
  output logic trg_pin, // Trigger pin.
  output logic cnt_pin, // Count pin.
  output logic t1_ovf, // Timer 1 overflow pulse.
  output int rx_n, // Receive ticks seen.
  output int tx_n // Transmit ticks seen.
);
  // ====================
  // Pin pulses
  // Lows last four clocks so the two-flop synchroniser cannot miss them.
  logic [2:0] trg_q = 3'h0;
  logic [2:0] cnt_q = 3'h0;
  logic t1_q = 1'b0;
  int rx_q = 0;
  int tx_q = 0;
  assign trg_pin = trg_q == 3'h0;
  assign cnt_pin = cnt_q == 3'h0;
  assign t1_ovf = t1_q;
  assign rx_n = rx_q;
  assign tx_n = tx_q;
  always @(posedge clk) begin
    trg_q <= cmd == 2'h1 ? 3'h4 : (trg_q == 3'h0 ? 3'h0 : trg_q - 3'h1);
    cnt_q <= cmd == 2'h2 ? 3'h4 : (cnt_q == 3'h0 ? 3'h0 : cnt_q - 3'h1);
    t1_q <= cmd == 2'h3;
    rx_q <= rx_q + int'(rx_tick);
    tx_q <= tx_q + int'(tx_tick);
  end
endmodule

// [bench/tmrcm_tb.sv]
// Purpose: Self-checking bench for the timer 2 control block.
// Assumes: Partner pulls pins low on command.
// Notes:   Register rows first, then hand-written cases.
`timescale 1ns/100ps
`include "tmrcm_defs.svh"
module testbench;
  import tmrcm_pkg::*;
  typedef struct packed {logic w; logic [9:0] i; tmrcm_byte_t d;} tmrcm_row_s;
  localparam logic [9:0] ctl = `TMRCM_IDX_CTRL, set = `TMRCM_IDX_CTRL_SET,
    clr = `TMRCM_IDX_CTRL_CLR, md = `TMRCM_IDX_MODE, ckm = `TMRCM_IDX_CKMODE,
    sta = `TMRCM_IDX_INT_STAT, msk = `TMRCM_IDX_INT_MASK, rl = `TMRCM_IDX_RELOAD_L,
    rh = `TMRCM_IDX_RELOAD_H, cl = `TMRCM_IDX_COUNT_L, ch = `TMRCM_IDX_COUNT_H;
  logic clk, prdy, perr, trg, cnt, t1, rxt, txt, cko, mc, tirq, irq, err;
  logic arst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0, prd;
  logic [1:0] cmd = 2'h0;
  int rxn, txn, n_mismatch, checked, k;
  tmrcm_byte_t r;
  tmrcm_row_s rows [14] = '{
    '{0, ctl, 8'h00}, '{0, md, 8'h00}, '{0, ckm, 8'h00}, '{0, sta, 8'h00},
    '{1, set, 8'h30}, '{0, ctl, 8'h30}, '{1, clr, 8'h10}, '{0, ctl, 8'h20},
    '{1, md, 8'h03}, '{0, md, 8'h03}, '{1, ckm, 8'h01}, '{0, ckm, 8'h01},
    '{1, ctl, 8'h00}, '{1, md, 8'h00}};
  tmrcm_top i_tmrcm_top (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .TRIGGER_PIN(trg), .COUNT_PIN(cnt), .TIMER1_OVF(t1), .RX_BAUD_TICK(rxt),
    .TX_BAUD_TICK(txt), .CLOCK_OUT(cko), .MC_TICK(mc), .TIMER_IRQ(tirq), .IRQ(irq));
  tmrcm_partner i_tmrcm_partner (.clk(clk), .cmd(cmd), .rx_tick(rxt), .tx_tick(txt),
    .trg_pin(trg), .cnt_pin(cnt), .t1_ovf(t1), .rx_n(rxn), .tx_n(txn));
  // ====================
  // Tasks
  task end_sim;
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input tmrcm_byte_t g, input tmrcm_byte_t e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task rw(input logic w, input logic [9:0] i, input tmrcm_byte_t d);
    psel <= 1'b1;
    pwr <= w;
    padr <= {i, 2'h0};
    pwd <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    r = prd[7:0];
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [9:0] i, input tmrcm_byte_t e);
    rw(1'b0, i, 8'h00);
    chk(r, e);
  endtask
  task pin(input logic [1:0] c);
    cmd <= c;
    @(posedge clk);
    cmd <= 2'h0;
    repeat (12) @(posedge clk);
  endtask
  // Measures the gap between two ticks; the first tick may follow a mode change.
  task per(input tmrcm_byte_t e);
    k = 1;
    while (mc !== 1'b1) @(posedge clk);
    @(posedge clk);
    while (mc !== 1'b1) begin
      @(posedge clk);
      k++;
    end
    chk(k[7:0], e);
  endtask
  // ====================
  // Sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[n]) begin
      rw(rows[n].w, rows[n].i, rows[n].d);
      if (!rows[n].w) chk(r, rows[n].d);
    end
    per(8'h06);
    rw(1'b1, ckm, 8'h00);
    repeat (20) @(posedge clk);
    per(8'h0C);
    rw(1'b0, 10'h0D3, 8'h00);
    chk1(err, 1'b1);
    chk(r, 8'h00);
    rw(1'b1, rl, 8'hFE);
    rw(1'b1, rh, 8'hFF);
    rw(1'b1, cl, 8'hFE);
    rw(1'b1, ch, 8'hFF);
    rw(1'b1, msk, 8'h01);
    rw(1'b1, ctl, 8'h04);
    repeat (40) @(posedge clk);
    chk1(tirq, 1'b1);
    chk1(irq, 1'b1);
    rw(1'b1, msk, 8'h00);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b0);
    rw(1'b1, clr, 8'h04);
    rd(ctl, 8'h80);
    rd(ch, 8'hFF);
    rw(1'b1, sta, 8'h01);
    rw(1'b1, msk, 8'h03);
    rd(sta, 8'h00);
    chk1(irq, 1'b0);
    rw(1'b1, ctl, 8'h35);
    repeat (60) @(posedge clk);
    chk1(rxn > 1 && txn > 1, 1'b1);
    rw(1'b1, set, 8'h08);
    pin(2'h1);
    rd(ctl, 8'h3D);
    rd(rh, 8'hFF);
    rw(1'b1, ctl, 8'h00);
    repeat (3) @(posedge clk);
    k = rxn + txn;
    pin(2'h3);
    chk1(rxn + txn == k + 2, 1'b1);
    rw(1'b1, ctl, 8'h08);
    rw(1'b1, cl, 8'h34);
    pin(2'h1);
    rd(ctl, 8'h48);
    rd(cl, 8'hFE);
    chk1(tirq, 1'b1);
    rw(1'b1, md, 8'h01);
    repeat (2) @(posedge clk);
    chk1(tirq, 1'b0);
    rw(1'b1, ctl, 8'h09);
    rw(1'b1, ch, 8'h12);
    pin(2'h1);
    rd(rh, 8'h12);
    rw(1'b1, ctl, 8'h00);
    pin(2'h1);
    rd(ctl, 8'h00);
    rw(1'b1, md, 8'h02);
    rw(1'b1, cl, 8'hFF);
    rw(1'b1, ch, 8'hFF);
    rw(1'b1, ctl, 8'h04);
    repeat (14) @(posedge clk);
    chk1(cko, 1'b1);
    rw(1'b1, ctl, 8'h00);
    rd(ch, 8'h12);
    rw(1'b1, md, 8'h01);
    rw(1'b1, cl, 8'h00);
    rw(1'b1, ctl, 8'h06);
    repeat (3) pin(2'h2);
    rw(1'b1, ctl, 8'h02);
    pin(2'h2);
    rd(cl, 8'h03);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ctl, 8'h00);
    rd(md, 8'h00);
    end_sim();
  end
endmodule

// [pkg/tmrcm_defs.svh]
// Purpose: Named constants for the timer 2 control and clock-mode block.
// Assumes: APB byte addresses are four times the register index.
// Notes:   Included by the package and by the block.
`ifndef TMRCM_DEFS_SVH
`define TMRCM_DEFS_SVH

// ==========================================================================
// Register indices (byte address = index * 4)
`define TMRCM_IDX_CTRL 10'h0C8
`define TMRCM_IDX_MODE 10'h0C9
`define TMRCM_IDX_CKMODE 10'h0CA
`define TMRCM_IDX_RELOAD_L 10'h0CB
`define TMRCM_IDX_RELOAD_H 10'h0CC
`define TMRCM_IDX_COUNT_L 10'h0CD
`define TMRCM_IDX_COUNT_H 10'h0CE
`define TMRCM_IDX_INT_STAT 10'h0CF
`define TMRCM_IDX_INT_MASK 10'h0D0
`define TMRCM_IDX_CTRL_SET 10'h0D1
`define TMRCM_IDX_CTRL_CLR 10'h0D2

// ==========================================================================
// Control register fields
`define TMRCM_B_OVF_FLAG 7
`define TMRCM_B_EXT_FLAG 6
`define TMRCM_B_RX_SEL 5
`define TMRCM_B_TX_SEL 4
`define TMRCM_B_EXT_EN 3
`define TMRCM_B_RUN 2
`define TMRCM_B_SRC_SEL 1
`define TMRCM_B_CAP_SEL 0
`define TMRCM_CTRL_RESET 8'h00

// Mode register fields.
`define TMRCM_B_CLKOUT_EN 1
`define TMRCM_B_UPDOWN_EN 0
`define TMRCM_MODE_RESET 2'h0

// Clock-mode register field.
`define TMRCM_B_DOUBLE 0
`define TMRCM_CKMODE_RESET 1'h0

// Interrupt status and mask fields.
`define TMRCM_I_OVF 0
`define TMRCM_I_EXT 1
`define TMRCM_INT_RESET 2'h0

// ==========================================================================
// Machine cycle lengths in oscillator periods
`define TMRCM_MC_STD 4'hC
`define TMRCM_MC_DOUBLE 4'h6
`define TMRCM_COUNT_MAX 16'hFFFF
`define TMRCM_ZERO16 16'h0000
`define TMRCM_RELOAD_RESET 8'h00

`endif

// [pkg/tmrcm_pkg.sv]
// Purpose: Shared types for the timer 2 control and clock-mode block.
// Assumes: Constants come from tmrcm_defs.svh.
// Notes:   Types only.
package tmrcm_pkg;
  `include "tmrcm_defs.svh"

  typedef logic [7:0] tmrcm_byte_t;
  typedef logic [15:0] tmrcm_word_t;
  typedef logic [31:0] tmrcm_data_t;
endpackage

// [rtl/tmrcm_top.sv]
// What this block does
// - Machine cycle is twelve or six periods.
// - Clock-mode bit resets to standard mode.
// - Reserved clock-mode bits read as zero.
// - Overflow flag set only outside baud mode.
// - Trigger capture or reload sets external flag.
// - External flag drives TIMER_IRQ except in up/down mode.
// - Receive select picks timer 1 or 2.
// - Transmit select picks timer 1 or 2.
// - Trigger edges honoured when enabled, not baud.
// - Run bit starts and stops counting.
// - Source select: machine cycles or count pin.
// - Baud mode forces auto-reload, ignores capture.
// - Reload mode: reload on overflow and on trigger edge.
// - Capture mode copies count on trigger edge.
// - Baud and clock-out share reload pair.
// - Control resets zero, bits individually settable.
// - Mode register holds clock-out, up/down enables.
//
// Purpose: Timer 2 control, counter, capture/reload and baud tick logic.
// Assumes: CLK is the oscillator; pins are asynchronous and synchronised here.
// Notes:   Registers sit on APB; PREADY comes one cycle into the access phase.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`include "tmrcm_defs.svh"

module tmrcm_top
  import tmrcm_pkg::*;
(
  input wire logic CLK, // Oscillator clock, 100 MHz.
  input wire logic ARST_N, // Asynchronous reset, active low.
  input wire logic PSEL, // APB select.
  input wire logic PENABLE, // APB access phase.
  input wire logic PWRITE, // APB direction, high for write.
  input wire logic [11:0] PADDR, // APB byte address.
  input wire logic [31:0] PWDATA, // APB write data.
  output logic [31:0] PRDATA, // APB read data.
  output logic PREADY, // APB ready.
  output logic PSLVERR, // APB error for unmapped address.
  input wire logic TRIGGER_PIN, // External trigger pin, falling edge active.
  input wire logic COUNT_PIN, // External count pin, falling edge active.
  input wire logic TIMER1_OVF, // Timer 1 overflow pulse, same clock.
  output logic RX_BAUD_TICK, // Serial receive clock tick.
  output logic TX_BAUD_TICK, // Serial transmit clock tick.
  output logic CLOCK_OUT, // Clock-out waveform.
  output logic MC_TICK, // One pulse per machine cycle.
  output logic TIMER_IRQ, // Timer 2 interrupt request.
  output logic IRQ // Masked sticky-status interrupt.
);

  // ========================================================================
  // Reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ========================================================================
  // Pin synchronisers and falling edge detection
  // The edge stage reads the second and third flops, never the first.
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic [1:0] pin_last_q;
  wire [1:0] pins_raw = {COUNT_PIN, TRIGGER_PIN};

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_meta_q <= 2'h3;
      pin_sync_q <= 2'h3;
      pin_last_q <= 2'h3;
    end else begin
      pin_meta_q <= pins_raw;
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
    end
  end

  wire [1:0] pin_fall = pin_last_q & ~pin_sync_q;
  wire trig_fall = pin_fall[0];
  wire count_fall = pin_fall[1];

  // ========================================================================
  // Register state
  tmrcm_byte_t ctrl_q;
  tmrcm_byte_t ctrl_d;
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic double_q;
  logic double_d;
  tmrcm_byte_t reload_l_q;
  tmrcm_byte_t reload_l_d;
  tmrcm_byte_t reload_h_q;
  tmrcm_byte_t reload_h_d;
  tmrcm_word_t count_q;
  tmrcm_word_t count_d;
  logic [1:0] int_stat_q;
  logic [1:0] int_stat_d;
  logic [1:0] int_mask_q;
  logic [1:0] int_mask_d;

  // ========================================================================
  // APB decode
  logic pready_q;
  logic pslverr_q;
  tmrcm_data_t prdata_q;

  wire [9:0] idx = PADDR[11:2];
  wire sel_ctrl = idx == `TMRCM_IDX_CTRL;
  wire sel_mode = idx == `TMRCM_IDX_MODE;
  wire sel_ckmode = idx == `TMRCM_IDX_CKMODE;
  wire sel_rel_l = idx == `TMRCM_IDX_RELOAD_L;
  wire sel_rel_h = idx == `TMRCM_IDX_RELOAD_H;
  wire sel_cnt_l = idx == `TMRCM_IDX_COUNT_L;
  wire sel_cnt_h = idx == `TMRCM_IDX_COUNT_H;
  wire sel_istat = idx == `TMRCM_IDX_INT_STAT;
  wire sel_imask = idx == `TMRCM_IDX_INT_MASK;
  wire sel_set = idx == `TMRCM_IDX_CTRL_SET;
  wire sel_clr = idx == `TMRCM_IDX_CTRL_CLR;
  wire mapped = sel_ctrl | sel_mode | sel_ckmode | sel_rel_l | sel_rel_h |
                sel_cnt_l | sel_cnt_h | sel_istat | sel_imask | sel_set | sel_clr;

  // The answer comes one cycle into the access phase; the write lands at the next edge, while PREADY is high.
  wire access = PSEL & PENABLE;
  wire answer_now = access & ~pready_q;
  wire commit = access & pready_q;
  wire wr = commit & PWRITE;
  wire [7:0] wbyte = PWDATA[7:0];

  wire [31:0] rd_mux =
    sel_ctrl ? {24'h000000, ctrl_q} :
    sel_set ? {24'h000000, ctrl_q} :
    sel_clr ? {24'h000000, ctrl_q} :
    sel_mode ? {30'h00000000, mode_q} :
    sel_ckmode ? {31'h00000000, double_q} :
    sel_rel_l ? {24'h000000, reload_l_q} :
    sel_rel_h ? {24'h000000, reload_h_q} :
    sel_cnt_l ? {24'h000000, count_q[7:0]} :
    sel_cnt_h ? {24'h000000, count_q[15:8]} :
    sel_istat ? {30'h00000000, int_stat_q} :
    sel_imask ? {30'h00000000, int_mask_q} :
    32'h00000000;

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= answer_now;
      pslverr_q <= answer_now & ~mapped;
      prdata_q <= answer_now ? rd_mux : 32'h00000000;
    end
  end

  // ========================================================================
  // Control field views
  wire ovf_flag = ctrl_q[`TMRCM_B_OVF_FLAG];
  wire ext_flag = ctrl_q[`TMRCM_B_EXT_FLAG];
  wire rx_sel = ctrl_q[`TMRCM_B_RX_SEL];
  wire tx_sel = ctrl_q[`TMRCM_B_TX_SEL];
  wire ext_en = ctrl_q[`TMRCM_B_EXT_EN];
  wire run = ctrl_q[`TMRCM_B_RUN];
  wire src_sel = ctrl_q[`TMRCM_B_SRC_SEL];
  wire cap_sel = ctrl_q[`TMRCM_B_CAP_SEL];
  wire clkout_en = mode_q[`TMRCM_B_CLKOUT_EN];
  wire updown_en = mode_q[`TMRCM_B_UPDOWN_EN];

  // ========================================================================
  // Machine cycle prescaler
  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic mc_q;

  wire [3:0] mc_len = double_q ? `TMRCM_MC_DOUBLE : `TMRCM_MC_STD;
  // A mode change mid-cycle may leave the count past the new end; wrap at once.
  wire pre_end = pre_q >= (mc_len - 4'h1);
  assign pre_d = pre_end ? 4'h0 : pre_q + 4'h1;

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pre_q <= 4'h0;
      mc_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      mc_q <= pre_end;
    end
  end

  // ========================================================================
  // Counter events
  wire baud_mode = rx_sel | tx_sel;
  wire count_in = src_sel ? count_fall : pre_end;
  wire inc = run & count_in;
  wire ovf = inc & (count_q == `TMRCM_COUNT_MAX);
  // Trigger edges are dropped while the timer clocks the serial port.
  wire ext_ev = trig_fall & ext_en & ~baud_mode;
  wire capture_now = ext_ev & cap_sel & ~baud_mode;
  wire reload_now = (ovf & (baud_mode | ~cap_sel)) | (ext_ev & ~cap_sel);
  wire ovf_flag_set = ovf & ~baud_mode;
  wire ext_flag_set = ext_ev;
  // One reload pair feeds both baud and clock-out rates.
  wire [15:0] reload_val = {reload_h_q, reload_l_q};

  // ========================================================================
  // Control register next value
  // Software writes, sets and clears bits; a hardware flag event beats a clear.
  wire [7:0] ctrl_sw =
    (wr & sel_ctrl) ? wbyte :
    (wr & sel_set) ? (ctrl_q | wbyte) :
    (wr & sel_clr) ? (ctrl_q & ~wbyte) :
    ctrl_q;
  wire [7:0] ctrl_hw = {ovf_flag_set, ext_flag_set, 6'h00};
  assign ctrl_d = ctrl_sw | ctrl_hw;

  assign mode_d = (wr & sel_mode) ? wbyte[1:0] : mode_q;
  assign double_d = (wr & sel_ckmode) ? wbyte[`TMRCM_B_DOUBLE] : double_q;
  assign int_mask_d = (wr & sel_imask) ? wbyte[1:0] : int_mask_q;

  wire [1:0] int_ev = {ext_flag_set, ovf_flag_set};
  wire [1:0] int_clr = (wr & sel_istat) ? wbyte[1:0] : 2'h0;
  assign int_stat_d = (int_stat_q & ~int_clr) | int_ev;

  // Capture writes the reload pair and wins over a software write there.
  assign reload_l_d = capture_now ? count_q[7:0] :
                      (wr & sel_rel_l) ? wbyte : reload_l_q;
  assign reload_h_d = capture_now ? count_q[15:8] :
                      (wr & sel_rel_h) ? wbyte : reload_h_q;

  // Software writes to the count take priority over counting in that cycle.
  wire [15:0] count_inc = count_q + 16'h0001;
  wire [15:0] count_hw = reload_now ? reload_val :
                         inc ? count_inc : count_q;
  assign count_d =
    (wr & sel_cnt_l) ? {count_q[15:8], wbyte} :
    (wr & sel_cnt_h) ? {wbyte, count_q[7:0]} :
    count_hw;

  // ========================================================================
  // Register update
  // One short process per register keeps each reset value beside its update.
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= `TMRCM_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= `TMRCM_MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      double_q <= `TMRCM_CKMODE_RESET;
    end else begin
      double_q <= double_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reload_l_q <= `TMRCM_RELOAD_RESET;
    end else begin
      reload_l_q <= reload_l_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reload_h_q <= `TMRCM_RELOAD_RESET;
    end else begin
      reload_h_q <= reload_h_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_q <= `TMRCM_ZERO16;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      int_stat_q <= `TMRCM_INT_RESET;
    end else begin
      int_stat_q <= int_stat_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      int_mask_q <= `TMRCM_INT_RESET;
    end else begin
      int_mask_q <= int_mask_d;
    end
  end

  // ========================================================================
  // Outputs
  logic rx_tick_q;
  logic tx_tick_q;
  logic clk_out_q;
  logic timer_irq_q;
  logic irq_q;

  wire rx_tick_d = rx_sel ? ovf : TIMER1_OVF;
  wire tx_tick_d = tx_sel ? ovf : TIMER1_OVF;
  // Clock-out toggles on overflow; it assumes software left the source at zero.
  wire clk_out_d = (ovf & clkout_en) ? ~clk_out_q : clk_out_q;
  wire timer_irq_d = ovf_flag | (ext_flag & ~updown_en);
  wire irq_d = |(int_stat_q & int_mask_q);

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_tick_q <= 1'b0;
    end else begin
      rx_tick_q <= rx_tick_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_tick_q <= 1'b0;
    end else begin
      tx_tick_q <= tx_tick_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      clk_out_q <= 1'b0;
    end else begin
      clk_out_q <= clk_out_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      timer_irq_q <= 1'b0;
    end else begin
      timer_irq_q <= timer_irq_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign RX_BAUD_TICK = rx_tick_q;
  assign TX_BAUD_TICK = tx_tick_q;
  assign CLOCK_OUT = clk_out_q;
  assign MC_TICK = mc_q;
  assign TIMER_IRQ = timer_irq_q;
  assign IRQ = irq_q;

endmodule
